// ### dsc_pkg.sv
/*
 * dsc_pkg: register map, control field positions, reset values and
 * pipeline depths of the synthesizer output and sleep control block.
 * assumes: one clock hclk, AHB-Lite register access, 32-bit words.
 */
package dsc_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] DSC_OFS_CTRL = 8'h00;
    localparam logic [7:0] DSC_OFS_FREQ0 = 8'h04;
    localparam logic [7:0] DSC_OFS_FREQ1 = 8'h08;
    localparam logic [7:0] DSC_OFS_PHASE0 = 8'h0C;
    localparam logic [7:0] DSC_OFS_PHASE1 = 8'h10;
    localparam logic [7:0] DSC_OFS_STATUS = 8'h14;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int DSC_B_WAVE_SEL = 1;
    localparam int DSC_B_HALF_RATE = 3;
    localparam int DSC_B_CMP_ROUTE = 4;
    localparam int DSC_B_DOUT_EN = 5;
    localparam int DSC_B_DAC_OFF = 6;
    localparam int DSC_B_CLK_STOP = 7;
    localparam int DSC_B_RESET = 8;
    localparam int DSC_B_HW_SEL = 9;
    localparam int DSC_B_PSEL = 10;
    localparam int DSC_B_FSEL = 11;
    localparam int DSC_CTRL_W = 12;
    // core held in reset after bus reset, so software can load words first
    localparam logic [DSC_CTRL_W-1:0] DSC_CTRL_RST = 12'h100;

    // ************************************************************
    // status register fields
    // ************************************************************
    localparam int DSC_S_DAC_DOWN = 0;
    localparam int DSC_S_CLK_RUN = 1;
    localparam int DSC_S_IN_RESET = 2;
    localparam int DSC_S_LIVE = 3;
    localparam int DSC_S_DATA_LSB = 16;

    // ************************************************************
    // datapath widths and pipeline
    // ************************************************************
    localparam int DSC_FREQ_W = 28;
    localparam int DSC_PHASE_W = 12;
    localparam int DSC_DAC_W = 10;
    localparam int DSC_DLY_STAGES = 4;
    // accumulator, phase add, wave, delay stages, dac register
    localparam int DSC_LATENCY = DSC_DLY_STAGES + 4;

endpackage

// ### dsc_release_sampler.sv
/*
 * dsc_release_sampler: passes a rising request straight through and
 * releases it only after the falling clock edge has seen it low.
 * assumes: req is a plain level from a pin or a control bit.
 */
`timescale 1ns/100ps

module dsc_release_sampler #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    output logic active
);

    logic held_ff;

    // falling edge capture; the rising side bypasses it entirely
    always_ff @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_ff <= RST_VAL;
        end else begin
            held_ff <= req;
        end
    end

    assign active = req | held_ff;

endmodule

// ### dsc_sine_lookup.sv
/*
 * dsc_sine_lookup: phase to signed amplitude, parabolic half-wave shape.
 * assumes: purely combinational, registered by the caller.
 */
`timescale 1ns/100ps

module dsc_sine_lookup
    import dsc_pkg::*;
#(
    parameter int PW = DSC_PHASE_W,
    parameter int DW = DSC_DAC_W
) (
    input wire logic [PW-1:0] phase,
    output logic [DW-1:0] amp
);

    localparam int HW = PW - 1;

    wire logic [HW-1:0] pos = phase[HW-1:0];
    wire logic [HW:0] rest = (HW+1)'(1 << HW) - {1'b0, pos};
    wire logic [2*HW:0] prod = {1'b0, pos} * rest;
    wire logic [2*HW-HW:0] scaled = prod[2*HW:HW];
    // peak would land one past the positive limit, so clip it
    wire logic [DW-1:0] mag = (scaled >= (2*HW-HW+1)'(1 << (DW-1)))
        ? DW'((1 << (DW-1)) - 1) : scaled[DW-1:0];

    assign amp = phase[PW-1] ? DW'(-mag) : mag;

endmodule

// ### dsc_output_ctrl.sv
/*
 * dsc_output_ctrl: sleep decode, phase accumulator pipeline, waveform
 * select and digital wave pin of the synthesizer, with AHB-Lite regs.
 * assumes: single AHB-Lite master, whole-word transfers, pins
 * synchronous to hclk, comparator result arriving as a level.
 */
// Our own choices: the placing of the registers and register access over AHB-Lite.
// How it works
// - hardware mode: sleep pin powers DAC down
// - software mode: two bits stop clock, DAC
// - stopped clock freezes accumulator and DAC value
// - register writes accepted while clock stopped
// - register selection changeable while clock stopped
// - clearing stop bit resumes through normal pipeline
// - sleep rise acts without clock
// - sleep fall released at falling clock edge
// - wave pin undriven unless output enabled
// - comparator routed when route and half-rate set
// - DAC MSB direct with half-rate set, halved with half-rate clear
// - waveform bit zero selects sine lookup
// - waveform bit one gives 10-bit triangle while output enable is clear, sine otherwise
// - reset clears pipeline, keeps words and control
// - data reaches DAC eight or nine cycles later
// - hardware select bit picks pins or bits
`timescale 1ns/100ps

module dsc_output_ctrl
    import dsc_pkg::*;
#(
    parameter int FW = DSC_FREQ_W,
    parameter int PW = DSC_PHASE_W,
    parameter int DW = DSC_DAC_W,
    parameter int DLY = DSC_DLY_STAGES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sleep_pin,
    input wire logic reset_pin,
    input wire logic freq_select_pin,
    input wire logic phase_select_pin,
    input wire logic comparator_in,
    output logic [DW-1:0] dac_data,
    output logic dac_power_down,
    output logic digital_wave_out,
    output logic digital_wave_oe
);

    // ************************************************************
    // bus slave
    // ************************************************************
    logic [7:0] wr_addr_ff;
    logic wr_pend_ff;
    logic [31:0] rdata_ff;
    logic [DSC_CTRL_W-1:0] ctrl_ff;
    logic [FW-1:0] freq0_ff;
    logic [FW-1:0] freq1_ff;
    logic [PW-1:0] phase0_ff;
    logic [PW-1:0] phase1_ff;
    logic [31:0] status;

    wire logic addr_take = hsel & htrans[1] & hready;
    wire logic [7:0] a_ofs = haddr[7:0];
    wire logic a_hit = (haddr[31:8] == 24'h00_0000);
    wire logic [31:0] rd_mux =
        !a_hit ? 32'h0000_0000 :
        (a_ofs == DSC_OFS_CTRL) ? {20'h0_0000, ctrl_ff} :
        (a_ofs == DSC_OFS_FREQ0) ? {4'h0, freq0_ff} :
        (a_ofs == DSC_OFS_FREQ1) ? {4'h0, freq1_ff} :
        (a_ofs == DSC_OFS_PHASE0) ? {20'h0_0000, phase0_ff} :
        (a_ofs == DSC_OFS_PHASE1) ? {20'h0_0000, phase1_ff} :
        (a_ofs == DSC_OFS_STATUS) ? status : 32'h0000_0000;

    // writes land in the data phase regardless of sleep state
    wire logic wr_ctrl = wr_pend_ff & (wr_addr_ff == DSC_OFS_CTRL);
    wire logic wr_f0 = wr_pend_ff & (wr_addr_ff == DSC_OFS_FREQ0);
    wire logic wr_f1 = wr_pend_ff & (wr_addr_ff == DSC_OFS_FREQ1);
    wire logic wr_p0 = wr_pend_ff & (wr_addr_ff == DSC_OFS_PHASE0);
    wire logic wr_p1 = wr_pend_ff & (wr_addr_ff == DSC_OFS_PHASE1);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_take & hwrite & a_hit;
            wr_addr_ff <= a_ofs;
            rdata_ff <= (addr_take & !hwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // the core reset leaves these alone; only the bus reset loads their reset values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= DSC_CTRL_RST;
            freq0_ff <= '0;
            freq1_ff <= '0;
            phase0_ff <= '0;
            phase1_ff <= '0;
        end else begin
            if (wr_ctrl) ctrl_ff <= hwdata[DSC_CTRL_W-1:0];
            if (wr_f0) freq0_ff <= hwdata[FW-1:0];
            if (wr_f1) freq1_ff <= hwdata[FW-1:0];
            if (wr_p0) phase0_ff <= hwdata[PW-1:0];
            if (wr_p1) phase1_ff <= hwdata[PW-1:0];
        end
    end

    // ************************************************************
    // control decode
    // ************************************************************
    wire logic hw_control_select = ctrl_ff[DSC_B_HW_SEL];
    wire logic clock_stop_bit = ctrl_ff[DSC_B_CLK_STOP];
    wire logic dac_off_bit = ctrl_ff[DSC_B_DAC_OFF];
    wire logic digital_out_enable = ctrl_ff[DSC_B_DOUT_EN];
    wire logic comparator_route_bit = ctrl_ff[DSC_B_CMP_ROUTE];
    wire logic half_rate_bit = ctrl_ff[DSC_B_HALF_RATE];
    wire logic waveform_select_bit = ctrl_ff[DSC_B_WAVE_SEL];

    // pins or bits govern sleep, reset and word selection
    wire logic reset_req = hw_control_select ? reset_pin : ctrl_ff[DSC_B_RESET];
    wire logic sleep_req = hw_control_select & sleep_pin;
    // selection stays live while the accumulator is frozen
    wire logic fsel = hw_control_select ? freq_select_pin : ctrl_ff[DSC_B_FSEL];
    wire logic psel = hw_control_select ? phase_select_pin : ctrl_ff[DSC_B_PSEL];

    logic sleep_act;
    logic core_reset;

    // rise passes through, fall waits for the falling edge
    dsc_release_sampler #(
        .RST_VAL(1'b0)
    ) u_sleep (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(sleep_req),
        .active(sleep_act)
    );

    dsc_release_sampler #(
        .RST_VAL(1'b1)
    ) u_reset (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(reset_req),
        .active(core_reset)
    );

    // pin alone in hardware mode, bits alone in software mode
    assign dac_power_down = hw_control_select ? sleep_act : dac_off_bit;
    // clearing the stop bit simply lets the pipeline run again
    wire logic clk_run = hw_control_select | !clock_stop_bit;
    wire logic advance = clk_run & !core_reset;

    // ************************************************************
    // phase accumulator pipeline
    // ************************************************************
    logic [FW-1:0] acc_ff;
    logic [PW-1:0] phs_ff;
    logic [DW-1:0] wave_ff;
    logic [DW-1:0] dly_ff [DLY];
    logic [DW-1:0] dac_data_ff;
    logic [DSC_LATENCY-1:0] live_ff;
    logic [DW-1:0] sine_amp;

    wire logic [FW-1:0] freq_word = fsel ? freq1_ff : freq0_ff;
    wire logic [PW-1:0] phase_word = psel ? phase1_ff : phase0_ff;
    wire logic [PW-1:0] phs_sum = acc_ff[FW-1:FW-PW] + phase_word;
    // fold the top of the phase into a rising then falling ramp
    wire logic [DW-1:0] tri_mag = phs_ff[PW-1] ? ~phs_ff[PW-2:PW-DW-1]
        : phs_ff[PW-2:PW-DW-1];
    wire logic [DW-1:0] tri_amp = {~tri_mag[DW-1], tri_mag[DW-2:0]};
    // triangle only with the digital pin off; otherwise sine
    wire logic use_tri = waveform_select_bit & !digital_out_enable;

    dsc_sine_lookup #(
        .PW(PW),
        .DW(DW)
    ) u_sine (
        .phase(phs_ff),
        .amp(sine_amp)
    );

    // core reset zeroes the pipeline to midscale, clock stop freezes it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff <= '0;
            phs_ff <= '0;
            wave_ff <= '0;
            dac_data_ff <= '0;
            live_ff <= '0;
        end else if (core_reset) begin
            acc_ff <= '0;
            phs_ff <= '0;
            wave_ff <= '0;
            dac_data_ff <= '0;
            live_ff <= '0;
        end else if (advance) begin
            acc_ff <= acc_ff + freq_word;
            // first sample waits for the first sum, so phase and frequency share one delay
            phs_ff <= live_ff[0] ? phs_sum : '0;
            wave_ff <= use_tri ? tri_amp : sine_amp;
            dac_data_ff <= dly_ff[DLY-1];
            live_ff <= {live_ff[DSC_LATENCY-2:0], 1'b1};
        end
    end

    // fixed delay so fresh data reaches the DAC on the eighth edge
    for (genvar i = 0; i < DLY; i++) begin : g_dly
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                dly_ff[i] <= '0;
            end else if (core_reset) begin
                dly_ff[i] <= '0;
            end else if (advance) begin
                dly_ff[i] <= (i == 0) ? wave_ff : dly_ff[(i == 0) ? 0 : i-1];
            end
        end
    end

    assign dac_data = dac_data_ff;
    wire logic out_live = live_ff[DSC_LATENCY-1];

    // ************************************************************
    // digital wave pin
    // ************************************************************
    logic msb_prev_ff;
    logic half_ff;
    logic wave_out_ff;

    wire logic dac_msb = dac_data_ff[DW-1];
    wire logic [1:0] route_sel = {comparator_route_bit, half_rate_bit};
    // reserved selections drive low; the host is expected to avoid them
    wire logic wave_nxt = waveform_select_bit ? 1'b0 :
        (route_sel == 2'b11) ? comparator_in :
        (route_sel == 2'b01) ? dac_msb :
        (route_sel == 2'b00) ? half_ff : 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msb_prev_ff <= 1'b0;
            half_ff <= 1'b0;
            wave_out_ff <= 1'b0;
        end else begin
            msb_prev_ff <= dac_msb;
            // toggle on each rising MSB gives the half-rate square
            if (core_reset) half_ff <= 1'b0;
            else if (dac_msb & !msb_prev_ff) half_ff <= !half_ff;
            wave_out_ff <= wave_nxt;
        end
    end

    assign digital_wave_out = wave_out_ff;
    assign digital_wave_oe = digital_out_enable;

    // ************************************************************
    // status
    // ************************************************************
    assign status = {6'h00, dac_data_ff, 12'h000, out_live, core_reset, clk_run,
        dac_power_down};

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_hw_sleep;
        hw_control_select |-> (!sleep_pin || dac_power_down) && (sleep_pin || $past(sleep_pin)
            || !dac_power_down);
    endproperty
    a_hw_sleep: assert property (p_hw_sleep) else $error("pin sleep not applied");

    property p_sw_sleep;
        !hw_control_select |-> dac_power_down == dac_off_bit && clk_run == !clock_stop_bit;
    endproperty
    a_sw_sleep: assert property (p_sw_sleep) else $error("sleep bits misdecoded");

    property p_hold;
        (!clk_run && !core_reset) ##1 !core_reset |-> $stable(dac_data_ff) && $stable(acc_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved while stopped");

    property p_wr_stopped;
        wr_f0 && !clk_run |=> freq0_ff == $past(hwdata[FW-1:0]);
    endproperty
    a_wr_stopped: assert property (p_wr_stopped) else $error("write lost in sleep");

    property p_hiz;
        !digital_out_enable |-> !digital_wave_oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("wave pin driven when off");

    property p_comp;
        !waveform_select_bit && route_sel == 2'b11 |=> digital_wave_out == $past(comparator_in);
    endproperty
    a_comp: assert property (p_comp) else $error("comparator not routed");

    property p_msb;
        !waveform_select_bit && route_sel == 2'b01 |=> digital_wave_out == $past(dac_msb);
    endproperty
    a_msb: assert property (p_msb) else $error("dac msb not routed");

    property p_midscale;
        core_reset |=> dac_data_ff == '0 && !out_live;
    endproperty
    a_midscale: assert property (p_midscale) else $error("pipeline not cleared");

    property p_latency;
        ($fell(core_reset) && clk_run) ##1 (clk_run && !core_reset) [*7] |-> !out_live ##1
            (out_live || core_reset);
    endproperty
    a_latency: assert property (p_latency) else $error("latency not eight");

    property p_half;
        dac_msb && !msb_prev_ff && !core_reset |=> half_ff != $past(half_ff);
    endproperty
    a_half: assert property (p_half) else $error("half rate did not toggle");

    c_stop_resume: cover property (!clk_run ##1 clk_run ##[1:20] out_live);
    c_half_out: cover property (digital_out_enable && route_sel == 2'b00 && half_ff);
    c_triangle: cover property (use_tri && out_live);
    c_pin_sleep: cover property (hw_control_select && $fell(sleep_pin) ##1 !dac_power_down);

endmodule

// ### dsc_host_model.sv
/*
 * dsc_host_model: host side of the synthesizer block, an AHB-Lite
 * master for single word transfers plus the sleep, reset, select and
 * comparator pins.
 * assumes: tasks are entered in the time step of a rising hclk edge.
 */
`timescale 1ns/100ps

module dsc_host_model (
    input wire logic hclk,
    input wire logic [31:0] hrdata,
    input wire logic hready,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic sleep_pin,
    output logic reset_pin,
    output logic freq_select_pin,
    output logic phase_select_pin,
    output logic comparator_in,
    output logic tmo
);
    // ****************************************
    // idle bus and pins
    // ****************************************
    // pins idle low, so the core leaves reset only when software says so
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        {sleep_pin, reset_pin, freq_select_pin, phase_select_pin, comparator_in} = 5'h00;
        tmo = 1'b0;
    end

    // ****************************************
    // bus and pin tasks
    // ****************************************
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            tmo <= 1'b1;
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        // released data lines do not keep the last value
        hwdata <= ~wd;
        haddr <= ~{24'h00_0000, a};
    endtask

    task automatic set_pins(input logic [4:0] v);
        {sleep_pin, reset_pin, freq_select_pin, phase_select_pin, comparator_in} <= v;
    endtask
endmodule

// ### dsc_output_ctrl_test.sv
/*
 * dsc_output_ctrl_test: self-checking bench of the output and sleep
 * control block, one task per scenario.
 * assumes: host model drives bus and pins, hready tied to hreadyout.
 */
`timescale 1ns/100ps

module dsc_output_ctrl_test;
    import dsc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, sleep_pin, reset_pin, tmo;
    logic freq_select_pin, phase_select_pin, comparator_in;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, dac_power_down, digital_wave_out, digital_wave_oe;
    logic [DSC_DAC_W-1:0] dac_data;
    int n_mismatch = 0;
    int n_tests = 0;

    dsc_output_ctrl i_dsc_output_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sleep_pin(sleep_pin), .reset_pin(reset_pin), .freq_select_pin(freq_select_pin),
        .phase_select_pin(phase_select_pin), .comparator_in(comparator_in),
        .dac_data(dac_data), .dac_power_down(dac_power_down),
        .digital_wave_out(digital_wave_out), .digital_wave_oe(digital_wave_oe));

    dsc_host_model i_dsc_host_model (.hclk(hclk), .hrdata(hrdata), .hready(hreadyout),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .sleep_pin(sleep_pin), .reset_pin(reset_pin),
        .freq_select_pin(freq_select_pin), .phase_select_pin(phase_select_pin),
        .comparator_in(comparator_in), .tmo(tmo));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        @(posedge hclk);
        i_dsc_host_model.xfer(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        @(posedge hclk);
        i_dsc_host_model.xfer(1'b0, a, 32'h0000_0000, r);
        check(r & m, e);
    endtask

    task automatic pins(input logic [4:0] v);
        @(posedge hclk);
        i_dsc_host_model.set_pins(v);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk(DSC_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0100);
        rd_chk(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
        check(dac_data, 0);
        check(digital_wave_oe, 0);
        check({hreadyout, hresp}, 32'h0000_0002);
    endtask

    task automatic t_sw_sleep();
        pins(5'h10);
        for (int i = 0; i < 4; i++) begin
            wr(DSC_OFS_CTRL, 32'h0000_0100 | (i << 6));
            #1 check(dac_power_down, i[0]);
            rd_chk(DSC_OFS_STATUS, 32'h0000_0003, {30'h0, ~i[1], i[0]});
        end
        pins(5'h00);
    endtask

    task automatic t_hw();
        // stop and dac-off bits set but ignored under pin control
        wr(DSC_OFS_CTRL, 32'h0000_02C0);
        #1 check(dac_power_down, 0);
        rd_chk(DSC_OFS_STATUS, 32'h0000_0003, 32'h0000_0002);
        pins(5'h10);
        #1 check(dac_power_down, 1);
        pins(5'h00);
        #1 check(dac_power_down, 1);
        @(negedge hclk);
        #1 check(dac_power_down, 0);
        pins(5'h08);
        rd_chk(DSC_OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
        pins(5'h00);
        rd_chk(DSC_OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
    endtask

    task automatic t_latency();
        int k;
        wr(DSC_OFS_CTRL, 32'h0000_0100);
        @(posedge hclk);
        #1 check(dac_data, 0);
        // words loaded while the core is held in reset
        wr(DSC_OFS_PHASE0, 32'h0000_0400);
        wr(DSC_OFS_FREQ0, 32'h0000_0000);
        wr(DSC_OFS_CTRL, 32'h0000_0000);
        k = 0;
        do begin
            @(posedge hclk);
            #1 k++;
        end while (dac_data === 0 && k < 20);
        check(k >= 8 && k <= 9, 1);
        wr(DSC_OFS_CTRL, 32'h0000_0100);
        rd_chk(DSC_OFS_PHASE0, 32'h0000_0FFF, 32'h0000_0400);
    endtask

    task automatic t_wave();
        // sleep pin and dac-off stay low while the analog code is judged
        wr(DSC_OFS_PHASE0, 32'h0000_0000);
        wr(DSC_OFS_CTRL, 32'h0000_0002);
        repeat (12) @(posedge hclk);
        #1 check(dac_data, 10'h200);
        wr(DSC_OFS_CTRL, 32'h0000_0000);
        repeat (12) @(posedge hclk);
        #1 check(dac_data, 10'h000);
    endtask

    task automatic t_freeze();
        logic [DSC_DAC_W-1:0] d;
        logic moved;
        wr(DSC_OFS_FREQ0, 32'h0100_0000);
        repeat (20) @(posedge hclk);
        wr(DSC_OFS_CTRL, 32'h0000_0080);
        repeat (2) @(posedge hclk);
        #1 d = dac_data;
        wr(DSC_OFS_FREQ1, 32'h0234_5678);
        wr(DSC_OFS_CTRL, 32'h0000_0880);
        repeat (10) @(posedge hclk);
        #1 check(dac_data, d);
        rd_chk(DSC_OFS_FREQ1, 32'h0FFF_FFFF, 32'h0234_5678);
        rd_chk(DSC_OFS_CTRL, 32'h0000_0FFF, 32'h0000_0880);
        wr(DSC_OFS_CTRL, 32'h0000_0800);
        moved = 1'b0;
        repeat (20) begin
            @(posedge hclk);
            #1 moved = moved | (dac_data !== d);
        end
        check(moved, 1);
    endtask

    task automatic t_digital();
        logic m;
        logic pw;
        int rises;
        int togs;
        // reserved output select combinations are never written
        wr(DSC_OFS_FREQ0, 32'h0100_0000);
        wr(DSC_OFS_CTRL, 32'h0000_0018);
        #1 check(digital_wave_oe, 0);
        wr(DSC_OFS_CTRL, 32'h0000_0038);
        #1 check(digital_wave_oe, 1);
        for (int c = 0; c < 4; c++) begin
            pins({4'h0, c[0]});
            @(posedge hclk);
            #1 check(digital_wave_out, c[0]);
        end
        wr(DSC_OFS_CTRL, 32'h0000_0028);
        #1 m = dac_data[DSC_DAC_W-1];
        repeat (20) begin
            @(posedge hclk);
            #1 check(digital_wave_out, m);
            m = dac_data[DSC_DAC_W-1];
        end
        wr(DSC_OFS_CTRL, 32'h0000_0020);
        // let the toggle reach the pin before counting
        repeat (4) @(posedge hclk);
        #1 m = dac_data[DSC_DAC_W-1];
        pw = digital_wave_out;
        rises = 0;
        togs = 0;
        repeat (64) begin
            @(posedge hclk);
            #1 rises += int'(dac_data[DSC_DAC_W-1] & ~m);
            togs += int'(digital_wave_out !== pw);
            m = dac_data[DSC_DAC_W-1];
            pw = digital_wave_out;
        end
        check(rises >= 3 && (rises - togs) <= 1 && (togs - rises) <= 1, 1);
    endtask

    // ****************************************
    // clock, reset, sequence and watchdogs
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    always @(posedge tmo) begin
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        hresetn = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_sw_sleep();
        t_hw();
        t_latency();
        t_wave();
        t_freeze();
        t_digital();
        tally_and_finish();
    end
endmodule
